/* rx_los_ais_violation_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module rx_los_ais_violation_monitor import rx_los_pkg::*; (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Line receiver and mode pins.
    input wire logic rec_clk_i,
    input wire logic ref_clk_i,
    input wire logic rx_line_plus_i,
    input wire logic rx_line_minus_i,
    input wire logic amp_low_i,
    input wire logic amp_high_i,
    input wire logic tx_neg_unipolar_select_i,
    input wire logic ami_code_select_pin_i,
    input wire logic data_recovery_mode_i,
    input wire logic host_mode_i,
    input wire logic [2:0] line_length_select_i,
    // Register port.
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Framer side.
    output logic rx_clk_o,
    output logic rx_positive_data_o,
    output logic rx_negative_data_o,
    output logic rx_unipolar_data_o,
    output logic signal_loss_flag_o,
    output logic violation_out_o
);
    function automatic logic [13:0] sat_inc(input logic [13:0] v);
        return (v == CNT_MAX) ? v : 14'(v + 14'h0001);
    endfunction

    function automatic logic [5:0] ones32(input logic [31:0] v);
        logic [5:0] n;
        n = 6'h00;
        for (int i = 0; i < 32; i++) begin
            n = 6'(n + {5'h00, v[i]});
        end
        return n;
    endfunction

    // --------------------------------------------------------------
    // Reset release and pin synchronisers
    // --------------------------------------------------------------
    logic [1:0] rst_sync_ff;
    logic rst_n;
    pins_t meta_ff, pins_ff;
    logic rec_prev_ff, ref_prev_ff;
    logic bit_stb, ref_stb, mark;

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) rst_sync_ff <= 2'h0;
        else rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
    assign rst_n = rst_sync_ff[1];

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n);

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            pins_ff <= '0;
            rec_prev_ff <= 1'b0;
            ref_prev_ff <= 1'b0;
        end else begin
            meta_ff <= {rec_clk_i, ref_clk_i, rx_line_plus_i, rx_line_minus_i,
                        amp_low_i, amp_high_i, tx_neg_unipolar_select_i,
                        ami_code_select_pin_i, data_recovery_mode_i, host_mode_i,
                        line_length_select_i};
            pins_ff <= meta_ff;
            rec_prev_ff <= pins_ff.rec_clk;
            ref_prev_ff <= pins_ff.ref_clk;
        end
    end
    assign bit_stb = pins_ff.rec_clk & ~rec_prev_ff;
    assign ref_stb = pins_ff.ref_clk & ~ref_prev_ff;
    assign mark = pins_ff.plus | pins_ff.minus;

    // --------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------
    logic [7:0] ctrl_ff, aie_ff, crit_sel_ff, status_ff, rdata_ff;
    logic e1, ami, insert_en, los_ff;
    crit_t crit;

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= REG_RESET;
            aie_ff <= REG_RESET;
            crit_sel_ff <= REG_RESET;
        end else if (reg_wr_i) begin
            if (reg_addr_i == CTRL_OFFSET) ctrl_ff <= reg_wdata_i;
            if (reg_addr_i == AIE_OFFSET) aie_ff <= reg_wdata_i;
            if (reg_addr_i == CRIT_SEL_OFFSET) crit_sel_ff <= {7'h00, reg_wdata_i[0]};
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) rdata_ff <= 8'h00;
        else if (reg_rd_i) begin
            unique case (reg_addr_i)
                CTRL_OFFSET: rdata_ff <= ctrl_ff;
                AIS_OFFSET: rdata_ff <= status_ff;
                AIE_OFFSET: rdata_ff <= aie_ff;
                CRIT_SEL_OFFSET: rdata_ff <= crit_sel_ff;
                default: rdata_ff <= 8'h00;
            endcase
        end
    end

    assign e1 = (pins_ff.len == 3'h0);
    assign ami = pins_ff.host ? ctrl_ff[AMI_BIT] : pins_ff.ami_pin;
    assign insert_en = ctrl_ff[INSERT_EN_BIT];

    always_comb begin
        if (pins_ff.drm) crit = CRIT_DR;
        else if (crit_sel_ff[0]) crit = CRIT_ETSI;
        else if (e1) crit = CRIT_G775;
        else crit = CRIT_T1;
    end

    // --------------------------------------------------------------
    // Loss monitor counters
    // --------------------------------------------------------------
    logic [13:0] zero_run_ff, nxt_zero_run, since_long_ff, hi_run_ff, nxt_hi_run;
    logic [13:0] t1_pos_ff, t1_marks_ff, dr_cnt_ff;
    logic [31:0] win_ff, nxt_win;
    logic t1_active_ff, clr_g775, t1_done_ok;

    assign nxt_zero_run = mark ? 14'h0000 : sat_inc(zero_run_ff);
    assign nxt_win = {win_ff[30:0], mark};
    assign nxt_hi_run = pins_ff.amp_high ? sat_inc(hi_run_ff) : 14'h0000;
    assign clr_g775 = (ones32(nxt_win) >= G775_MARKS) && (since_long_ff >= G775_WIN)
                      && pins_ff.amp_high;
    assign t1_done_ok = t1_active_ff && (sat_inc(t1_pos_ff) == T1_WIN)
                        && (14'(t1_marks_ff + {13'h0000, mark}) >= T1_MARKS);

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            zero_run_ff <= 14'h0000;
            win_ff <= 32'h00000000;
            since_long_ff <= 14'h0000;
            hi_run_ff <= 14'h0000;
        end else if (bit_stb) begin
            zero_run_ff <= nxt_zero_run;
            win_ff <= nxt_win;
            since_long_ff <= (nxt_zero_run > G775_MAX_RUN) ? 14'h0000
                             : sat_inc(since_long_ff);
            hi_run_ff <= nxt_hi_run;
        end
    end

    // T1.231 density window opens on a pulse received during loss.
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            t1_active_ff <= 1'b0;
            t1_pos_ff <= 14'h0000;
            t1_marks_ff <= 14'h0000;
        end else if (!los_ff) begin
            t1_active_ff <= 1'b0;
        end else if (bit_stb) begin
            if (!t1_active_ff) begin
                t1_active_ff <= mark;
                t1_pos_ff <= 14'h0001;
                t1_marks_ff <= 14'h0001;
            end else begin
                t1_active_ff <= (sat_inc(t1_pos_ff) != T1_WIN);
                t1_pos_ff <= sat_inc(t1_pos_ff);
                t1_marks_ff <= 14'(t1_marks_ff + {13'h0000, mark});
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) dr_cnt_ff <= 14'h0000;
        else if (pins_ff.amp_low && !pins_ff.amp_high) dr_cnt_ff <= sat_inc(dr_cnt_ff);
        else dr_cnt_ff <= 14'h0000;
    end

    // --------------------------------------------------------------
    // Loss flag
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) los_ff <= 1'b0;
        else if (crit == CRIT_DR) begin
            if (pins_ff.amp_high) los_ff <= 1'b0;
            else if (dr_cnt_ff >= DR_LOSS_CYC) los_ff <= 1'b1;
        end else if (bit_stb) begin
            unique case (crit)
                CRIT_G775: begin
                    if (!los_ff && nxt_zero_run >= G775_LOSS_BITS) los_ff <= 1'b1;
                    else if (los_ff && clr_g775) los_ff <= 1'b0;
                end
                CRIT_ETSI: begin
                    if (!los_ff && nxt_zero_run >= ETSI_LOSS_BITS) los_ff <= 1'b1;
                    else if (los_ff && nxt_hi_run > ETSI_CLEAR_BITS) los_ff <= 1'b0;
                end
                CRIT_T1: begin
                    if (!los_ff && nxt_zero_run >= T1_LOSS_BITS) los_ff <= 1'b1;
                    else if (los_ff && t1_done_ok) los_ff <= 1'b0;
                end
                CRIT_DR: los_ff <= los_ff;
            endcase
        end
    end

    g775_loss_a: assert property (bit_stb && crit == CRIT_G775 && !los_ff
        && nxt_zero_run >= G775_LOSS_BITS |=> los_ff) else $error("G.775 loss missed");
    etsi_loss_a: assert property (bit_stb && crit == CRIT_ETSI && !los_ff
        && nxt_zero_run >= ETSI_LOSS_BITS |=> los_ff) else $error("ETSI loss missed");
    t1_loss_a: assert property (bit_stb && crit == CRIT_T1 && !los_ff
        && nxt_zero_run >= T1_LOSS_BITS |=> los_ff) else $error("T1.231 loss missed");
    dr_loss_a: assert property (crit == CRIT_DR && !pins_ff.amp_high
        && dr_cnt_ff >= DR_LOSS_CYC |=> los_ff) else $error("DR loss missed");
    zero_clear_a: assert property (bit_stb && mark |=> zero_run_ff == 14'h0000)
        else $error("zero run not cleared");

    // --------------------------------------------------------------
    // Receive clock selection
    // --------------------------------------------------------------
    logic sel_ref_ff, rx_clk_ff;

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) sel_ref_ff <= 1'b0;
        else if (los_ff) sel_ref_ff <= 1'b1;
        else if (ref_stb) sel_ref_ff <= 1'b0;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) rx_clk_ff <= 1'b0;
        else rx_clk_ff <= sel_ref_ff ? pins_ff.ref_clk : pins_ff.rec_clk;
    end

    sequence ref_wait_s;
        sel_ref_ff && !los_ff && !ref_stb;
    endsequence
    ref_swap_a: assert property ($rose(los_ff) |-> ##1 sel_ref_ff)
        else $error("no swap to reference clock");
    ref_hold_a: assert property (ref_wait_s |=> sel_ref_ff)
        else $error("left reference clock off its edge");

    // --------------------------------------------------------------
    // Alarm detection and receive data
    // --------------------------------------------------------------
    logic ais_en, ref_alive, ais_det_ff, insert, pos_ff, neg_ff;
    logic [7:0] ref_to_ff;
    logic [13:0] ais_pos_ff, ais_zeros_ff, nxt_ais_zeros, ais_period, ais_thr;

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) ref_to_ff <= REF_TIMEOUT_CYC;
        else if (ref_stb) ref_to_ff <= 8'h00;
        else if (ref_to_ff != REF_TIMEOUT_CYC) ref_to_ff <= 8'(ref_to_ff + 8'h01);
    end
    assign ref_alive = (ref_to_ff != REF_TIMEOUT_CYC);
    // Loopback settings are deliberately not an input here.
    assign ais_en = pins_ff.host && !pins_ff.drm && ref_alive;
    assign ais_period = e1 ? AIS_E1_PERIOD : AIS_T1_PERIOD;
    assign ais_thr = e1 ? AIS_E1_ZEROS : AIS_T1_ZEROS;
    assign nxt_ais_zeros = mark ? ais_zeros_ff : sat_inc(ais_zeros_ff);
    assign insert = los_ff && insert_en && !pins_ff.drm;

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            ais_pos_ff <= 14'h0000;
            ais_zeros_ff <= 14'h0000;
            ais_det_ff <= 1'b0;
        end else if (!ais_en) begin
            ais_pos_ff <= 14'h0000;
            ais_zeros_ff <= 14'h0000;
        end else if (bit_stb) begin
            // A block left longer by a change of standard closes at once.
            if (sat_inc(ais_pos_ff) >= ais_period) begin
                ais_det_ff <= (nxt_ais_zeros < ais_thr);
                ais_pos_ff <= 14'h0000;
                ais_zeros_ff <= 14'h0000;
            end else begin
                ais_pos_ff <= sat_inc(ais_pos_ff);
                ais_zeros_ff <= nxt_ais_zeros;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) status_ff <= 8'h00;
        else if (bit_stb) begin
            if (insert) status_ff <= {7'h00, !mark};
            else if (los_ff) status_ff <= status_ff;
            else if (ais_en) status_ff <= {7'h00, ais_det_ff};
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            pos_ff <= 1'b0;
            neg_ff <= 1'b0;
        end else if (bit_stb) begin
            pos_ff <= insert | pins_ff.plus;
            neg_ff <= insert | pins_ff.minus;
        end
    end

    insert_ones_a: assert property (bit_stb && insert |=> pos_ff && neg_ff)
        else $error("all ones not inserted");
    pass_data_a: assert property (bit_stb && !insert |=> pos_ff == $past(pins_ff.plus)
        && neg_ff == $past(pins_ff.minus)) else $error("data not passed");
    status_hold_a: assert property (bit_stb && los_ff && !insert_en |=> $stable(status_ff))
        else $error("status moved without insert enable");

    // --------------------------------------------------------------
    // Unipolar select and violation monitor
    // --------------------------------------------------------------
    logic [4:0] ubs_cnt_ff;
    logic unipolar, last_pol_ff, have_pulse_ff, sub_ff, pol_repeat, legal, viol_ff, udata_ff;

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) ubs_cnt_ff <= 5'h00;
        else if (!pins_ff.uni_sel) ubs_cnt_ff <= 5'h00;
        else if (ref_stb && ubs_cnt_ff <= USEL_REF_CYCLES) ubs_cnt_ff <= 5'(ubs_cnt_ff + 5'h01);
    end
    assign unipolar = (ubs_cnt_ff > USEL_REF_CYCLES);

    assign pol_repeat = have_pulse_ff && (pins_ff.plus == last_pol_ff);
    always_comb begin
        if (ami) legal = 1'b0;
        else if (e1) legal = (zero_run_ff == 14'h0003) || (zero_run_ff == 14'h0002);
        else legal = (zero_run_ff == 14'h0003) || (zero_run_ff == 14'h0001 && sub_ff);
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            last_pol_ff <= 1'b0;
            have_pulse_ff <= 1'b0;
            sub_ff <= 1'b0;
        end else if (bit_stb && mark) begin
            last_pol_ff <= pins_ff.plus;
            have_pulse_ff <= 1'b1;
            if (pol_repeat && legal && zero_run_ff == 14'h0003) sub_ff <= 1'b1;
            else if (zero_run_ff != 14'h0000) sub_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            viol_ff <= 1'b0;
            udata_ff <= 1'b0;
        end else if (bit_stb) begin
            viol_ff <= unipolar && mark && pol_repeat && !legal;
            udata_ff <= mark;
        end
    end

    viol_mode_a: assert property ($rose(viol_ff) |-> $past(unipolar) && $past(bit_stb))
        else $error("violation outside unipolar mode");

    assign reg_rdata_o = rdata_ff;
    assign rx_clk_o = rx_clk_ff;
    assign rx_positive_data_o = pos_ff;
    assign rx_negative_data_o = neg_ff;
    assign rx_unipolar_data_o = udata_ff;
    assign signal_loss_flag_o = los_ff;
    assign violation_out_o = viol_ff;
endmodule // rx_los_ais_violation_monitor
`default_nettype wire

/* rx_los_pkg.sv */
// Operation
// - Zero-run counter counts received zeros per recovered bit, resets on a mark.
// - On loss, receive clock output takes reference clock; returns after loss clears.
// - Receive data outputs keep following the line input during loss while insert enable is clear.
// - G.775: loss declared after 32 consecutive zero intervals.
// - G.775 clear: 4 marks in 32-bit window, no run over 15, amplitude high.
// - G.775: return to recovered clock happens at next reference clock edge.
// - ETSI mode: loss declared after 2048 consecutive zero intervals.
// - ETSI mode: loss clears after more than 32 intervals at high amplitude.
// - Criteria select bit picks ETSI; else G.775 for E1, T1.231 for T1.
// - T1.231: loss declared after 175 contiguous zero positions.
// - T1.231 clear: 12.5% density over 175 positions, window starts at a pulse.
// - Data recovery: amplitude only, loss after 30 us low, clears when high.
// - Alarm detection only in host mode, clock recovery, reference clock running.
// - Alarm detection runs whatever loopback is active.
// - E1 alarm: fewer than 3 zeros in 512 bits declares, 3 or more clears.
// - T1 alarm: fewer than 9 zeros in 8192 bits declares, 9 or more clears.
// - Insert enable clear: loss inserts nothing and leaves alarm status alone.
// - Insert enable set in loss, clock recovery only: all ones on positive and negative data outputs; status follows zeros/ones input.
// - Violation reporting only in unipolar mode, chosen by select high over 16 cycles.
// - AMI: every same-polarity pulse pair is reported as violation.
// - HDB3/B8ZS: one-bit violation pulse unless part of legal substitution.
// - HDB3 in E1, B8ZS in T1; line length zero means E1.
// - AMI chosen by control bit 4 in host mode, by pin in hardware mode.
package rx_los_pkg;
    localparam logic [7:0] CTRL_OFFSET = 8'h0F;
    localparam logic [7:0] AIS_OFFSET = 8'h13;
    localparam logic [7:0] AIE_OFFSET = 8'h14;
    localparam logic [7:0] CRIT_SEL_OFFSET = 8'h20;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int INSERT_EN_BIT = 6;
    localparam int AMI_BIT = 4;
    localparam int CNT_W = 14;
    localparam logic [13:0] CNT_MAX = 14'h3FFF;
    localparam logic [13:0] G775_LOSS_BITS = 14'h0020;
    localparam logic [5:0] G775_MARKS = 6'h04;
    localparam logic [13:0] G775_MAX_RUN = 14'h000F;
    localparam logic [13:0] G775_WIN = 14'h0020;
    localparam logic [13:0] ETSI_LOSS_BITS = 14'h0800;
    localparam logic [13:0] ETSI_CLEAR_BITS = 14'h0020;
    localparam logic [13:0] T1_LOSS_BITS = 14'h00AF;
    localparam logic [13:0] T1_WIN = 14'h00AF;
    localparam logic [13:0] T1_MARKS = 14'h0016;
    localparam logic [13:0] AIS_E1_PERIOD = 14'h0200;
    localparam logic [13:0] AIS_E1_ZEROS = 14'h0003;
    localparam logic [13:0] AIS_T1_PERIOD = 14'h2000;
    localparam logic [13:0] AIS_T1_ZEROS = 14'h0009;
    localparam logic [4:0] USEL_REF_CYCLES = 5'h10;
    localparam int CLK_NS = 10;
    localparam int DR_LOSS_NS = 30000;
    localparam logic [13:0] DR_LOSS_CYC = 14'((DR_LOSS_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] REF_TIMEOUT_CYC = 8'hFF;

    typedef struct packed {
        logic rec_clk;
        logic ref_clk;
        logic plus;
        logic minus;
        logic amp_low;
        logic amp_high;
        logic uni_sel;
        logic ami_pin;
        logic drm;
        logic host;
        logic [2:0] len;
    } pins_t;

    typedef enum logic [1:0] {CRIT_G775, CRIT_ETSI, CRIT_T1, CRIT_DR} crit_t;
endpackage

/* line_source.sv */
`timescale 1ns/1ps
`default_nettype none
module line_source (
    // Sliced line toward the monitor.
    output logic rec_clk_o,
    output logic plus_o,
    output logic minus_o
);
    initial begin
        rec_clk_o = 1'b0;
        plus_o = 1'b0;
        minus_o = 1'b0;
    end

    // One bit of 80 ns; the clock only runs while bits are sent.
    task automatic send(input logic p, input logic m);
        plus_o = p;
        minus_o = m;
        #20 rec_clk_o = 1'b1;
        #40 rec_clk_o = 1'b0;
        // Past the hold time the lines no longer show the bit.
        plus_o = ~p;
        minus_o = ~m;
        #20;
    endtask
endmodule // line_source
`default_nettype wire

/* rx_los_ais_violation_monitor_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module rx_los_ais_violation_monitor_tb;
    logic clk_sys_i, reset_n_i, ref_clk, amp_low, amp_high, uni_sel, wr_s, rd_s, pol;
    logic [2:0] len;
    logic [7:0] addr, wdata, rdata;
    wire logic rec_clk, plus, minus;
    logic rx_clk, rx_pos, rx_neg, rx_uni, loss, viol;
    int err_total, tests_run;

    line_source src (.rec_clk_o(rec_clk), .plus_o(plus), .minus_o(minus));
    rx_los_ais_violation_monitor DUT (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .rec_clk_i(rec_clk), .ref_clk_i(ref_clk), .rx_line_plus_i(plus),
        .rx_line_minus_i(minus), .amp_low_i(amp_low), .amp_high_i(amp_high),
        .tx_neg_unipolar_select_i(uni_sel), .ami_code_select_pin_i(1'b0),
        .data_recovery_mode_i(1'b0), .host_mode_i(1'b1), .line_length_select_i(len),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
        .reg_rdata_o(rdata), .rx_clk_o(rx_clk), .rx_positive_data_o(rx_pos),
        .rx_negative_data_o(rx_neg), .rx_unipolar_data_o(rx_uni),
        .signal_loss_flag_o(loss), .violation_out_o(viol));

    // ----------------------------------------
    // Clocks and shared tasks
    // ----------------------------------------
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        ref_clk = 1'b0;
        forever #30.5 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        #1 addr = a;
        wdata = d;
        wr_s = 1'b1;
        @(posedge clk_sys_i);
        #1 wr_s = 1'b0;
    endtask
    task automatic rdx(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys_i);
        #1 addr = a;
        rd_s = 1'b1;
        @(posedge clk_sys_i);
        #1 rd_s = 1'b0;
        @(posedge clk_sys_i);
        #1 chk(rdata, e);
    endtask
    task automatic zeros(input int n);
        repeat (n) src.send(1'b0, 1'b0);
    endtask
    // Marks of alternating polarity, each followed by gap zeros.
    task automatic marks(input int n, input int gap);
        repeat (n) begin
            src.send(pol, ~pol);
            pol = ~pol;
            zeros(gap);
        end
    endtask
    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #600000;
        err_total++;
        give_verdict();
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        {reset_n_i, amp_low, amp_high, uni_sel, wr_s, rd_s, pol} = 7'h00;
        {len, addr, wdata} = 19'h0;
        err_total = 0;
        tests_run = 0;
        repeat (4) @(posedge clk_sys_i);
        #1 reset_n_i = 1'b1;
        repeat (3) @(posedge clk_sys_i);
        rdx(8'h0F, 8'h00);
        wr(8'h0F, 8'h50);
        rdx(8'h0F, 8'h50);
        wr(8'h14, 8'hA5);
        rdx(8'h14, 8'hA5);
        wr(8'h13, 8'hFF);
        rdx(8'h13, 8'h00);
        rdx(8'h55, 8'h00);
        wr(8'h20, 8'hFF);
        rdx(8'h20, 8'h01);
        wr(8'h20, 8'h00);
        wr(8'h0F, 8'h00);
        $display("register test done");
        amp_low = 1'b1;
        zeros(31);
        chk({7'h00, loss}, 8'h00);
        zeros(1);
        chk({7'h00, loss}, 8'h01);
        rdx(8'h13, 8'h00);
        src.send(1'b1, 1'b0);
        chk({6'h00, rx_pos, rx_neg}, 8'h02);
        {amp_low, amp_high} = 2'b01;
        marks(1, 3);
        chk({7'h00, loss}, 8'h01);
        marks(8, 3);
        chk({7'h00, loss}, 8'h00);
        $display("g775 test done");
        wr(8'h14, 8'h00);
        wr(8'h0F, 8'h40);
        {amp_low, amp_high} = 2'b10;
        zeros(32);
        chk({6'h00, rx_pos, rx_neg}, 8'h03);
        rdx(8'h13, 8'h01);
        src.send(1'b1, 1'b0);
        rdx(8'h13, 8'h00);
        {amp_low, amp_high} = 2'b01;
        marks(9, 3);
        wr(8'h0F, 8'h00);
        $display("insertion test done");
        wr(8'h20, 8'h01);
        {amp_low, amp_high} = 2'b10;
        // The previous scenario ends on three zeros, so the run starts at three.
        zeros(2044);
        chk({7'h00, loss}, 8'h00);
        zeros(1);
        chk({7'h00, loss}, 8'h01);
        {amp_low, amp_high} = 2'b01;
        marks(32, 0);
        chk({7'h00, loss}, 8'h01);
        marks(1, 0);
        chk({7'h00, loss}, 8'h00);
        wr(8'h20, 8'h00);
        $display("etsi test done");
        len = 3'h4;
        {amp_low, amp_high} = 2'b10;
        zeros(174);
        chk({7'h00, loss}, 8'h00);
        zeros(1);
        chk({7'h00, loss}, 8'h01);
        {amp_low, amp_high} = 2'b01;
        marks(22, 7);
        chk({7'h00, loss}, 8'h00);
        len = 3'h0;
        $display("t1 test done");
        marks(1024, 0);
        rdx(8'h13, 8'h01);
        marks(128, 7);
        rdx(8'h13, 8'h00);
        $display("alarm test done");
        src.send(1'b1, 1'b0);
        src.send(1'b1, 1'b0);
        chk({7'h00, viol}, 8'h00);
        uni_sel = 1'b1;
        #2000;
        wr(8'h0F, 8'h10);
        src.send(1'b1, 1'b0);
        src.send(1'b1, 1'b0);
        chk({7'h00, viol}, 8'h01);
        wr(8'h0F, 8'h00);
        src.send(1'b0, 1'b1);
        zeros(1);
        src.send(1'b0, 1'b1);
        chk({6'h00, viol, rx_uni}, 8'h03);
        zeros(3);
        src.send(1'b0, 1'b1);
        chk({7'h00, viol}, 8'h00);
        $display("violation test done");
        give_verdict();
    end
endmodule // rx_los_ais_violation_monitor_tb
`default_nettype wire
